// ---- rtl/ctp_pkg.sv ----
// Purpose: Constants for the cascaded timer, event counter and PWM unit
// Assumes: AXI4-Lite slave, byte address is four times the index
// Notes:   Registers hold 8 bits in byte lane 0, upper bits read zero
package ctp_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h20; // Run and cascade bits
  localparam logic [7:0] IDX_MODE = 8'h21; // Upper half mode
  localparam logic [7:0] IDX_CMPL = 8'h22; // Compare low byte
  localparam logic [7:0] IDX_CMPH = 8'h23; // Compare high byte
  localparam logic [7:0] IDX_SYS  = 8'h24; // Prescale select
  localparam logic [7:0] IDX_CNTL = 8'h25; // Counter low, read only
  localparam logic [7:0] IDX_CNTH = 8'h26; // Counter high, read only
  localparam logic [7:0] IDX_PWML = 8'h28; // PWM low register
  localparam logic [7:0] IDX_PWMH = 8'h29; // PWM high register
  localparam logic [7:0] A_CTRL = IDX_CTRL * 8'h04;
  localparam logic [7:0] A_MODE = IDX_MODE * 8'h04;
  localparam logic [7:0] A_CMPL = IDX_CMPL * 8'h04;
  localparam logic [7:0] A_CMPH = IDX_CMPH * 8'h04;
  localparam logic [7:0] A_SYS  = IDX_SYS * 8'h04;
  localparam logic [7:0] A_CNTL = IDX_CNTL * 8'h04;
  localparam logic [7:0] A_CNTH = IDX_CNTH * 8'h04;
  localparam logic [7:0] A_PWML = IDX_PWML * 8'h04;
  localparam logic [7:0] A_PWMH = IDX_PWMH * 8'h04;

  // ----------------------------------------------------------------
  // Field positions, codes and reset values
  // ----------------------------------------------------------------
  localparam int RUN_LO = 0; // Control: lower run bit
  localparam int RUN_HI = 1; // Control: upper run bit
  localparam int CASC   = 2; // Control: cascade_enable
  localparam int M_DIV  = 0; // Mode: clk_div_sel, 3 bits
  localparam int M_EXT  = 3; // Mode: hi_ext_input_sel
  localparam int M_OP   = 4; // Mode: hi_op_mode, 2 bits
  localparam int M_DBUF = 6; // Mode: dbuf_enable
  localparam int M_INIT = 7; // Mode: PWM pin idle level
  localparam int S_SLOW = 0; // System: slow_prescale_sel
  localparam logic [1:0] OP_PWM = 2'b10; // 12-bit PWM
  localparam logic [1:0] RSP_OK  = 2'b00;
  localparam logic [1:0] RSP_ERR = 2'b10;
  localparam logic [7:0] PWM_RST = 8'hff;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] GRP_END = 4'hf; // Last cycle of 16

  // Write channel states
  typedef enum logic [1:0] {
    WS_IDLE = 2'b01,
    WS_RESP = 2'b10
  } ctp_wst_type;

endpackage

// ---- rtl/ctp_timer.sv ----
// Purpose: Cascaded 16-bit timer, event counter and 12-bit PWM
// Assumes: aclk is the gear clock, subclock and event pin are async
// Notes:   Registers reached over AXI4-Lite, one access at a time
`timescale 1ns/1ps
module ctp_timer (
  input  wire logic        aclk,               // Gear clock
  input  wire logic        aresetn,            // Sync reset, low
  input  wire logic [7:0]  awaddr,             // Write address
  input  wire logic        awvalid,            // Write addr valid
  output logic             awready,            // Write addr ready
  input  wire logic [31:0] wdata,              // Write data
  input  wire logic [3:0]  wstrb,              // Byte strobes
  input  wire logic        wvalid,             // Write data valid
  output logic             wready,             // Write data ready
  output logic [1:0]       bresp,              // Write response
  output logic             bvalid,             // Response valid
  input  wire logic        bready,             // Response ready
  input  wire logic [7:0]  araddr,             // Read address
  input  wire logic        arvalid,            // Read addr valid
  output logic             arready,            // Read addr ready
  output logic [31:0]      rdata,              // Read data
  output logic [1:0]       rresp,              // Read response
  output logic             rvalid,             // Read data valid
  input  wire logic        rready,             // Read data ready
  input  wire logic        event_input_pin,    // External count pin
  input  wire logic        low_speed_subclock, // Slow clock, async
  output logic             pwm_output_pin,     // PWM waveform
  output logic             match_irq,          // Match pulse
  output logic             ovf_irq             // Overflow pulse
);
  import ctp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ctp_wst_type  wst_ff;           // Write channel state
  logic         aw_have_ff;       // Address held
  logic         w_have_ff;        // Data held
  logic [7:0]   aw_addr_ff;       // Held address
  logic [7:0]   w_data_ff;        // Held low byte
  logic         w_lane_ff;        // Lane 0 strobe held
  logic [7:0]   ctrl_ff;          // timer_pair_ctrl
  logic [7:0]   mode_ff;          // hi_mode_reg
  logic [7:0]   sys_ff;           // system_ctrl1
  logic [7:0]   cmp_lo_ff;        // Staged low compare byte
  logic [15:0]  cmp_buf_ff;       // Compare double buffer
  logic [15:0]  cmp_act_ff;       // Effective compare value
  logic [7:0]   pwm_lo_ff;        // Staged PWM low byte
  logic [15:0]  pwm_buf_ff;       // PWM double buffer
  logic [11:0]  pwm_act_ff;       // Effective PWM value
  logic [15:0]  cnt_ff;           // Up counter
  logic [3:0]   cyc_ff;           // Cycle within 16-cycle group
  logic [10:0]  pre_ff;           // Gear clock prescaler
  logic [3:0]   sub_cnt_ff;       // Subclock divider
  logic [2:0]   ev_sync_ff;       // Event pin sync chain
  logic [2:0]   sub_sync_ff;      // Subclock sync chain
  logic         wr_go, wr_en, wr_map, rd_map, wr_hit;
  logic         running, tmr_mode, pwm_mode, src_tick, int_tick;
  logic         ev_fall, sub_rise, tmr_hit, grp_end, init_lvl;
  logic [15:0]  cnt_inc;          // Counter plus one
  logic [8:0]   cnt8_inc;         // Low byte plus one
  logic [8:0]   pwm_thr;          // Duty plus extra pulse
  logic [7:0]   rd_byte;          // Read mux result

  // Extra pulse in cycle cyc+1 of the group
  // extra pulse cycles
  function automatic logic pulse_add(input logic [3:0] ad,
                                     input logic [3:0] cyc);
    logic [4:0] c;
    c = {1'b0, cyc} + 5'd1;
    pulse_add = (!c[0] && ad[3]) || (c[1:0] == 2'b11 && ad[2]) ||
                (c[2:0] == 3'b101 && ad[1]) || (c == 5'd9 && ad[0]);
  endfunction

  // ----------------------------------------------------------------
  // Mode decode and source clock
  // ----------------------------------------------------------------
  // lower half ignored
  assign running  = ctrl_ff[RUN_HI] && ctrl_ff[CASC];
  assign tmr_mode = !mode_ff[M_OP+1];
  assign pwm_mode = mode_ff[M_OP+1 -: 2] == OP_PWM;
  assign init_lvl = mode_ff[M_INIT];
  assign ev_fall  = ev_sync_ff[2] && !ev_sync_ff[1];
  assign sub_rise = sub_sync_ff[1] && !sub_sync_ff[2];

  // Divider taps; subclock taps only on codes 000 and 001
  // source clock select
  always_comb begin
    case (mode_ff[M_DIV +: 3])
      3'b000: int_tick = sys_ff[S_SLOW] ? sub_rise && &sub_cnt_ff
                                        : &pre_ff;
      3'b001: int_tick = sys_ff[S_SLOW] ? sub_rise && &sub_cnt_ff[2:0]
                                        : &pre_ff[9:0];
      3'b010: int_tick = &pre_ff[7:0];
      3'b011: int_tick = &pre_ff[5:0];
      3'b100: int_tick = &pre_ff[3:0];
      3'b101: int_tick = &pre_ff[1:0];
      3'b110: int_tick = pre_ff[0];
      default: int_tick = 1'b1;
    endcase
  end

  assign src_tick = mode_ff[M_EXT] ? ev_fall : int_tick;
  assign cnt_inc  = cnt_ff + 16'h0001;
  assign cnt8_inc = {1'b0, cnt_ff[7:0]} + 9'h001;
  assign pwm_thr  = {1'b0, pwm_act_ff[11:4]} +
                    {8'h00, pulse_add(pwm_act_ff[3:0], cyc_ff)};
  assign tmr_hit  = running && tmr_mode && src_tick &&
                    cnt_inc == cmp_act_ff;
  assign grp_end  = running && pwm_mode && src_tick &&
                    cnt_ff[7:0] == 8'hff && cyc_ff == GRP_END;

  // Synchronisers; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_sync_ff  <= 3'b111;
      sub_sync_ff <= 3'b000;
    end else begin
      ev_sync_ff  <= {ev_sync_ff[1:0], event_input_pin};
      sub_sync_ff <= {sub_sync_ff[1:0], low_speed_subclock};
    end
  end

  // Prescalers run freely so tick phase is arbitrary at start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_ff     <= 11'h000;
      sub_cnt_ff <= 4'h0;
    end else begin
      pre_ff <= pre_ff + 11'h001;
      if (sub_rise)
        sub_cnt_ff <= sub_cnt_ff + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Counter, PWM pin and interrupt pulses
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff         <= 16'h0000;
      cyc_ff         <= 4'h0;
      match_irq      <= 1'b0;
      ovf_irq        <= 1'b0;
      pwm_output_pin <= 1'b0;
    end else begin
      match_irq <= 1'b0;
      ovf_irq   <= 1'b0;
      if (!running) begin
        cnt_ff         <= 16'h0000;
        cyc_ff         <= 4'h0;
        pwm_output_pin <= init_lvl;
      end else if (src_tick && pwm_mode) begin
        if (cnt_ff[7:0] == 8'hff) begin
          cnt_ff         <= 16'h0000;
          ovf_irq        <= 1'b1;
          cyc_ff         <= cyc_ff + 4'h1;
          pwm_output_pin <= (pwm_thr == 9'h000) ? !init_lvl : init_lvl;
          match_irq      <= cyc_ff == GRP_END;
        end else begin
          cnt_ff <= {8'h00, cnt8_inc[7:0]};
          if (cnt8_inc == pwm_thr)
            pwm_output_pin <= !init_lvl;
        end
      end else if (src_tick && tmr_mode) begin
        if (tmr_hit) begin
          cnt_ff    <= 16'h0000;
          match_irq <= 1'b1;
        end else begin
          cnt_ff <= cnt_inc;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign wr_go = aw_have_ff && w_have_ff && wst_ff == WS_IDLE;
  assign wr_en = wr_go && w_lane_ff;
  assign wr_hit = wr_en && aw_addr_ff == A_CMPH;

  // Control and system registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= REG_RST;
      sys_ff  <= REG_RST;
    end else if (wr_en) begin
      if (aw_addr_ff == A_CTRL)
        ctrl_ff <= w_data_ff;
      if (aw_addr_ff == A_SYS)
        sys_ff <= w_data_ff;
    end
  end

  // Mode locked while either half runs, avoids glitching the count
  // mode write lockout
  always_ff @(posedge aclk) begin
    if (!aresetn)
      mode_ff <= REG_RST;
    else if (wr_en && aw_addr_ff == A_MODE &&
             !ctrl_ff[RUN_HI] && !ctrl_ff[RUN_LO])
      mode_ff <= w_data_ff;
  end

  // Compare pair, high write commits both bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_lo_ff  <= REG_RST;
      cmp_buf_ff <= 16'h0000;
      cmp_act_ff <= 16'h0000;
    end else begin
      if (wr_en && aw_addr_ff == A_CMPL)
        cmp_lo_ff <= w_data_ff;
      if (wr_hit)
        cmp_buf_ff <= {w_data_ff, cmp_lo_ff};
      if (wr_hit && (!mode_ff[M_DBUF] || !running))
        cmp_act_ff <= {w_data_ff, cmp_lo_ff};
      else if (tmr_hit && mode_ff[M_DBUF])
        cmp_act_ff <= cmp_buf_ff;
    end
  end

  // PWM pair, reset to all ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_lo_ff  <= PWM_RST;
      pwm_buf_ff <= {PWM_RST, PWM_RST};
      pwm_act_ff <= {PWM_RST[3:0], PWM_RST};
    end else begin
      if (wr_en && aw_addr_ff == A_PWML)
        pwm_lo_ff <= w_data_ff;
      if (wr_en && aw_addr_ff == A_PWMH) begin
        pwm_buf_ff <= {w_data_ff, pwm_lo_ff};
        if (!mode_ff[M_DBUF] || !running)
          pwm_act_ff <= {w_data_ff[3:0], pwm_lo_ff};
      end else if (grp_end && mode_ff[M_DBUF]) begin
        pwm_act_ff <= pwm_buf_ff[11:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  always_comb begin
    case (aw_addr_ff)
      A_CTRL, A_MODE, A_CMPL, A_CMPH, A_SYS,
      A_CNTL, A_CNTH, A_PWML, A_PWMH: wr_map = 1'b1;
      default:                        wr_map = 1'b0;
    endcase
  end

  // Address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 8'h00;
      w_lane_ff  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= awaddr;
        awready    <= 1'b0;
      end else if (wr_go) begin
        aw_have_ff <= 1'b0;
      end else begin
        awready <= !aw_have_ff && wst_ff == WS_IDLE;
      end
      if (wvalid && wready) begin
        w_have_ff <= 1'b1;
        w_data_ff <= wdata[7:0];
        w_lane_ff <= wstrb[0];
        wready    <= 1'b0;
      end else if (wr_go) begin
        w_have_ff <= 1'b0;
      end else begin
        wready <= !w_have_ff && wst_ff == WS_IDLE;
      end
    end
  end

  // Response state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_ff <= WS_IDLE;
      bvalid <= 1'b0;
      bresp  <= RSP_OK;
    end else begin
      case (wst_ff)
        WS_IDLE: if (wr_go) begin
          wst_ff <= WS_RESP;
          bvalid <= 1'b1;
          bresp  <= wr_map ? RSP_OK : RSP_ERR;
        end
        WS_RESP: if (bready) begin
          wst_ff <= WS_IDLE;
          bvalid <= 1'b0;
        end
        default: wst_ff <= WS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  // Pair reads return the last pair committed by a high write, not the effective one
  always_comb begin
    rd_map = 1'b1;
    case (araddr)
      A_CTRL:  rd_byte = ctrl_ff;
      A_MODE:  rd_byte = mode_ff;
      A_CMPL:  rd_byte = cmp_buf_ff[7:0];
      A_CMPH:  rd_byte = cmp_buf_ff[15:8];
      A_SYS:   rd_byte = sys_ff;
      A_CNTL:  rd_byte = cnt_ff[7:0];
      A_CNTH:  rd_byte = cnt_ff[15:8];
      A_PWML:  rd_byte = pwm_buf_ff[7:0];
      A_PWMH:  rd_byte = pwm_buf_ff[15:8];
      default: begin
        rd_byte = 8'h00;
        rd_map  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RSP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h000000, rd_byte};
      rresp   <= rd_map ? RSP_OK : RSP_ERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= !rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_match_clears: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tmr_hit |=> match_irq && cnt_ff == 16'h0000)
    else $error("timer match did not clear counter");
  a_stop_clears: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !running |=> cnt_ff == 16'h0000 && !match_irq && !ovf_irq)
    else $error("stopped counter not cleared");
  a_mode_locked: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ctrl_ff[RUN_HI] |=> $stable(mode_ff))
    else $error("mode changed while running");
  a_ovf_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ovf_irq |-> cnt_ff == 16'h0000 && $past(cnt_ff[7:0]) == 8'hff)
    else $error("overflow not at 256 counts");
  a_group_match: assert property (
    @(posedge aclk) disable iff (!aresetn)
    pwm_mode && ovf_irq |-> match_irq == (cyc_ff == 4'h0))
    else $error("group match not on sixteenth overflow");
  a_event_step: assert property (
    @(posedge aclk) disable iff (!aresetn)
    running && tmr_mode && mode_ff[M_EXT] && !ev_fall
    |=> $stable(cnt_ff))
    else $error("event counter moved without edge");
  a_dbuf_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    running && mode_ff[M_DBUF] && !tmr_hit |=> $stable(cmp_act_ff))
    else $error("buffered compare loaded before match");
  a_lo_staged: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !wr_hit |=> $stable(cmp_buf_ff))
    else $error("compare buffer changed without high write");
  a_div_full: assert property (
    @(posedge aclk) disable iff (!aresetn)
    running && tmr_mode && !mode_ff[M_EXT] && !tmr_hit &&
    mode_ff[M_DIV +: 3] == 3'b111 |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("undivided source clock missing ticks");

endmodule

// ---- verif/ctp_ev_src.sv ----
// Purpose: Event pulse source driving the counter input pin
// Assumes: One low pulse per fire request, pin idles high
// Notes:   Phase length is clamped so a pulse is never too short
`timescale 1ns/1ps
module ctp_ev_src (
  input  wire logic       aclk, // Gear clock
  input  wire logic       fire, // Request one pulse
  input  wire logic [3:0] half, // Phase length, cycles
  output logic            pin   // Event output
);
  int n; // Phase length in use
  // One process owns the pin, idle high from the start
  // two cycle phase floor
  initial begin
    pin = 1'b1;
    forever begin
      @(posedge aclk);
      if (fire === 1'b1) begin
        n = (half < 4'h2) ? 2 : int'(half);
        pin <= 1'b0;
        repeat (n) @(posedge aclk);
        pin <= 1'b1;
        repeat (n) @(posedge aclk);
      end
    end
  end
endmodule

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the cascaded timer unit
// Assumes: Registers in byte lane 0, counter registers read only
// Notes:   Register model and match tallies give all expectations but counter reads and pin levels
`timescale 1ns/1ps
module tb;
  import ctp_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, subclk;
  logic        ev_pin, fire, pwm_pin, match_irq, ovf_irq;
  logic [7:0]  awaddr, araddr, seed;
  logic [3:0]  wstrb, half;
  logic [1:0]  bresp, rresp;
  logic [31:0] wdata, rdata;
  int          failures, checks, g, lw, ov, nn, m0;
  int          since = 0, lows = 0, ovfs = 0, nm = 0;
  int          dv[6] = '{256, 64, 16, 4, 2, 1}; // Divisors, codes 2..7
  logic [7:0]  rm [logic [7:0]];       // Register model

  ctp_timer ctp_timer_inst (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .event_input_pin(ev_pin),
    .low_speed_subclock(subclk), .pwm_output_pin(pwm_pin),
    .match_irq(match_irq), .ovf_irq(ovf_irq));
  ctp_ev_src ctp_ev_src_inst (.aclk(aclk), .fire(fire), .half(half),
    .pin(ev_pin));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Subclock of 160 ns for the slow prescale path
  initial begin
    subclk = 1'b0;
    forever #80 subclk = ~subclk;
  end
  // Tallies since the last match pulse, and a running total of match pulses
  always @(posedge aclk) begin
    since <= (match_irq === 1'b1) ? 0 : since + 1;
    lows <= (match_irq === 1'b1) ? 0 : lows + int'(pwm_pin === 1'b0);
    ovfs <= (match_irq === 1'b1) ? 0 : ovfs + int'(ovf_irq === 1'b1);
    nm <= nm + int'(match_irq === 1'b1);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [1:0] rsp(input logic [7:0] a);
    return (rm.exists(a) || a == A_CNTL || a == A_CNTH) ? RSP_OK : RSP_ERR;
  endfunction
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic a_ok, w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge aclk);
      if (!a_ok && awready === 1'b1) begin
        a_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, rsp(a));
    // Mode stays frozen while either run bit is set
    // Lane 0 strobe low leaves every register as it was
    if (rm.exists(a) && wstrb[0] &&
        !(a == A_MODE && rm[A_CTRL][1:0] != 2'b00))
      rm[a] = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {24'h0, e});
    chk(rresp, rsp(a));
  endtask
  task automatic wm(output int gap, output int low, output int ovc);
    do @(posedge aclk); while (match_irq !== 1'b1);
    gap = since + 1;
    low = lows + int'(pwm_pin === 1'b0);
    ovc = ovfs + int'(ovf_irq === 1'b1);
  endtask
  // Falling edges with random phase length, spaced well apart
  task automatic ev(input int k);
    repeat (k) begin
      seed = step(seed);
      half <= {2'b00, seed[1:0]} + 4'h2;
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (12) @(posedge aclk);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    end_sim();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fire} = '0;
    {awaddr, araddr, wdata, half} = '0;
    wstrb = 4'h1;
    seed = 8'h3a;
    rm[A_CTRL] = 8'h00;
    rm[A_MODE] = 8'h00;
    rm[A_CMPL] = 8'h00;
    rm[A_CMPH] = 8'h00;
    rm[A_SYS] = 8'h00;
    rm[A_PWML] = 8'hff;
    rm[A_PWMH] = 8'hff;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rm[a]) rd(a, rm[a]);
    rd(8'h00, 8'h00);
    wr(8'hfc, 8'h55);
    wstrb <= 4'h0;
    wr(A_SYS, 8'h01);
    wstrb <= 4'h1;
    rd(A_SYS, rm[A_SYS]);
    $display("test reset and map done");
    wr(A_MODE, 8'h08);
    wr(A_CMPL, 8'h03);
    wr(A_CMPH, 8'h00);
    wr(A_CTRL, 8'h02);
    ev(1);
    rd(A_CNTL, 8'h00);
    wr(A_CTRL, 8'h06);
    ev(2);
    rd(A_CNTL, 8'h02);
    wr(A_MODE, 8'hff);
    rd(A_MODE, rm[A_MODE]);
    m0 = nm;
    ev(1);
    chk(nm - m0, 1);
    rd(A_CNTL, 8'h00);
    ev(1);
    wr(A_CTRL, 8'h04);
    rd(A_CNTL, 8'h00);
    rd(A_CNTH, 8'h00);
    $display("test event counter done");
    seed = step(seed);
    nn = 4 + int'(seed[3:0]);
    wr(A_CMPL, nn[7:0]);
    wr(A_CMPH, 8'h00);
    for (int c = 2; c < 10; c++) begin
      if (c == 8) wr(A_SYS, 8'h01);
      wr(A_MODE, (c < 8) ? 8'(c) : 8'(9 - c));
      wr(A_CTRL, 8'h06);
      wm(g, lw, ov);
      wm(g, lw, ov);
      m0 = nn * ((c == 8) ? 64 : 128);
      if (c < 8) chk(g, nn * dv[c - 2]);
      else chk(int'(g >= m0 - 2 && g <= m0 + 2), 1);
      wr(A_CTRL, 8'h04);
    end
    wr(A_SYS, 8'h00);
    $display("test clock select done");
    for (int db = 0; db < 2; db++) begin
      wr(A_MODE, (db == 1) ? 8'h47 : 8'h07);
      wr(A_CMPL, 8'h14);
      wr(A_CMPH, 8'h00);
      wr(A_CTRL, 8'h06);
      wm(g, lw, ov);
      wr(A_CMPL, 8'h1e);
      wr(A_CMPH, 8'h00);
      wm(g, lw, ov);
      chk(g, (db == 1) ? 20 : 30);
      wm(g, lw, ov);
      chk(g, 30);
      rd(A_CMPL, rm[A_CMPL]);
      wr(A_CTRL, 8'h04);
    end
    $display("test double buffer done");
    seed = step(seed);
    wr(A_PWML, seed);
    wr(A_PWMH, {5'h00, seed[6:4]} | 8'h01);
    rd(A_PWMH, rm[A_PWMH]);
    wr(A_MODE, 8'h27);
    wr(A_CTRL, 8'h06);
    wm(g, lw, ov);
    wm(g, lw, ov);
    chk(g, 4096);
    chk(ov, 16);
    nn = 16 * int'({rm[A_PWMH][3:0], rm[A_PWML][7:4]});
    chk(lw, nn + int'(rm[A_PWML][3:0]));
    wr(A_CTRL, 8'h04);
    repeat (2) @(posedge aclk);
    chk(pwm_pin, 1'b0);
    wr(A_MODE, 8'ha7);
    repeat (2) @(posedge aclk);
    chk(pwm_pin, 1'b1);
    $display("test pwm done");
    end_sim();
  end
endmodule
